/* File: rtfcc_pkg.sv */
/*
  rtfcc_pkg: register offsets, field positions, reset values and encodings
  for the receive/transmit configuration control block.
  Assumes a 32-bit host register port with byte addresses.
*/
package rtfcc_pkg;
  localparam logic [7:0]  RTFCC_OFF_RX_CFG      = 8'h6C;
  localparam logic [7:0]  RTFCC_OFF_TX_CFG      = 8'h70;
  // receive configuration fields
  localparam int          RTFCC_RX_ALIGN_HI     = 31;
  localparam int          RTFCC_RX_ALIGN_LO     = 30;
  localparam int          RTFCC_RX_FLUSH_BIT    = 15;
  localparam int          RTFCC_RX_OFF_HI       = 12;
  localparam int          RTFCC_RX_OFF_LO       = 8;
  // transmit configuration fields
  localparam int          RTFCC_TX_SFLUSH_BIT   = 15;
  localparam int          RTFCC_TX_DFLUSH_BIT   = 14;
  localparam int          RTFCC_TX_SOA_BIT      = 2;
  localparam int          RTFCC_TX_ON_BIT       = 1;
  localparam int          RTFCC_TX_STOP_BIT     = 0;
  // reset values
  localparam logic [1:0]  RTFCC_RST_ALIGN       = 2'h0;
  localparam logic [4:0]  RTFCC_RST_OFFSET      = 5'h00;
  // end alignment codes
  typedef enum logic [1:0] {
    RTFCC_ALIGN_4  = 2'b00,
    RTFCC_ALIGN_16 = 2'b01,
    RTFCC_ALIGN_32 = 2'b10,
    RTFCC_ALIGN_RSV = 2'b11
  } rtfcc_align_type;
  // dwords per alignment unit
  localparam logic [3:0]  RTFCC_DW_4            = 4'h1;
  localparam logic [3:0]  RTFCC_DW_16           = 4'h4;
  localparam logic [3:0]  RTFCC_DW_32           = 4'h8;
endpackage

/* File: rtfcc_pad.sv */
/*
  rtfcc_pad: counts dwords read from a receive buffer and, on the last
  data transfer, demands filler dwords up to the selected end alignment.
  Assumes one read pulse per dword and a last-data flag from the FIFO.
*/
`timescale 1ns/1ns
module rtfcc_pad
  import rtfcc_pkg::*;
(
  input  wire logic       clk_sys,     // system clock
  input  wire logic       rst_n,       // sync reset, low
  input  wire logic       clear,       // flush resets position
  input  wire logic [1:0] align,       // end alignment code
  input  wire logic       rd,          // host dword read
  input  wire logic       last_data,   // read carries last real dword
  output logic            pad_active,  // filler dwords being returned
  output logic            pad_dword    // current read is filler
);
  logic [2:0] pos;
  logic [3:0] unit;

  // reserved code treated as plain dword alignment
  always_comb begin
    case (align)
      RTFCC_ALIGN_16: unit = RTFCC_DW_16;
      RTFCC_ALIGN_32: unit = RTFCC_DW_32;
      default:        unit = RTFCC_DW_4;
    endcase
  end

  assign pad_dword = pad_active;

  // position within the alignment unit, filler until the boundary
  always_ff @(posedge clk_sys) begin
    if (!rst_n || clear) begin
      pos        <= 3'h0;
      pad_active <= 1'b0;
    end else if (rd) begin
      if ({1'b0, pos} + 4'h1 >= unit) begin
        pos        <= 3'h0;
        pad_active <= 1'b0;
      end else begin
        pos        <= pos + 3'h1;
        pad_active <= pad_active | last_data;
      end
    end
  end
endmodule // rtfcc_pad

/* File: rtfcc_top.sv */
/*
  rtfcc_top: receive and transmit configuration registers with flush,
  receive data offset, end-alignment padding and transmitter start/stop.
  Assumes a single-cycle host register port in the clk_sys domain and
  a transmit engine that reports frame-in-progress and status-full.
  The offset low bits are applied at once, so the host must keep the
  receiver halted and purged while it changes them; nothing here checks
  that, and a mid-packet change would corrupt the byte lanes.
*/
`timescale 1ns/1ns
module rtfcc_top
  import rtfcc_pkg::*;
(
  input  wire logic        clk_sys,         // system clock, 50 MHz
  input  wire logic        rst_n,           // sync reset, low
  input  wire logic [7:0]  reg_addr,        // register byte address
  input  wire logic        reg_wr,          // write strobe
  input  wire logic        reg_rd,          // read strobe
  input  wire logic [31:0] reg_wdata,       // write data
  output logic [31:0]      reg_rdata,       // read data, registered
  input  wire logic        tx_busy,         // frame in progress
  input  wire logic        tsf_full,        // tx status FIFO full
  input  wire logic        rx_rd,           // rx data dword read
  input  wire logic        rx_last,         // read holds last real dword
  output logic             rx_ptr_clear,    // pulse: zero rx data/status pointers
  output logic             txs_ptr_clear,   // pulse: zero tx status pointers
  output logic             txd_ptr_clear,   // pulse: zero tx data pointers
  output logic [4:0]       rx_offset_eff,   // offset applied to packet start
  output logic             rx_pad,          // current read is filler dword
  output logic             tx_run,          // transmitter may send
  output logic             tsf_full_irq     // status full event to irq logic
);
  logic [1:0] receive_align;
  logic [4:0] receive_byte_offset;
  logic       status_overrun_allow;
  logic       tx_on;
  logic       stop_req;
  logic       pad_active;
  logic       pad_dword;
  logic       wr_rx;
  logic       wr_tx;
  logic       tx_halted;
  logic       wr_rx_flush;      // write of one to receive flush
  logic       wr_txs_flush;     // write of one to status flush
  logic       wr_txd_flush;     // write of one to data flush
  logic       wr_stop;          // write of one to stop request
  logic       suspend_full;     // full status FIFO holds sending
  logic       next_tx_run;      // send permission for next cycle
  logic [4:0] next_offset_eff;  // offset applied after this edge
  logic [31:0] next_rdata;      // readback word before its register

  assign wr_rx     = reg_wr && (reg_addr == RTFCC_OFF_RX_CFG);
  assign wr_tx     = reg_wr && (reg_addr == RTFCC_OFF_TX_CFG);
  // halted once no frame remains in flight
  assign tx_halted = !tx_busy;

  // per-bit write strobes; a written zero reaches none of them
  assign wr_rx_flush  = wr_rx && reg_wdata[RTFCC_RX_FLUSH_BIT];
  assign wr_txs_flush = wr_tx && reg_wdata[RTFCC_TX_SFLUSH_BIT];
  assign wr_txd_flush = wr_tx && reg_wdata[RTFCC_TX_DFLUSH_BIT];
  assign wr_stop      = wr_tx && reg_wdata[RTFCC_TX_STOP_BIT];

  // receive configuration storage
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      receive_align       <= RTFCC_RST_ALIGN;
      receive_byte_offset <= RTFCC_RST_OFFSET;
    end else if (wr_rx) begin
      receive_align       <= reg_wdata[RTFCC_RX_ALIGN_HI:RTFCC_RX_ALIGN_LO];
      // low bits trusted to be changed only when halted
      receive_byte_offset <= reg_wdata[RTFCC_RX_OFF_HI:RTFCC_RX_OFF_LO];
    end
  end

  // low bits follow the register at once, the host keeping the receiver
  // halted meanwhile; upper dword bits must wait for the next dword read
  always_comb begin
    next_offset_eff      = rx_offset_eff;
    next_offset_eff[1:0] = receive_byte_offset[1:0];
    if (rx_rd) begin
      next_offset_eff[4:2] = receive_byte_offset[4:2];
    end
  end

  // effective offset register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_offset_eff <= RTFCC_RST_OFFSET;
    end else begin
      rx_offset_eff <= next_offset_eff;
    end
  end

  // flush pulses; the bits themselves never store, so read as zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_ptr_clear  <= 1'b0;
      txs_ptr_clear <= 1'b0;
      txd_ptr_clear <= 1'b0;
    end else begin
      rx_ptr_clear  <= wr_rx_flush;
      txs_ptr_clear <= wr_txs_flush;
      txd_ptr_clear <= wr_txd_flush;
    end
  end

  // overrun allow is plain storage
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_overrun_allow <= 1'b0;
    end else if (wr_tx) begin
      status_overrun_allow <= reg_wdata[RTFCC_TX_SOA_BIT];
    end
  end

  // stop request: set by write of one, locked while high, cleared on halt
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stop_req <= 1'b0;
    end else if (stop_req) begin
      if (tx_halted) begin
        stop_req <= 1'b0;
      end
    end else if (wr_stop) begin
      stop_req <= 1'b1;
    end
  end

  // enable: cleared by hardware when the stop completes, halt wins over write
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_on <= 1'b0;
    end else if (stop_req && tx_halted) begin
      tx_on <= 1'b0;
    end else if (wr_tx) begin
      tx_on <= reg_wdata[RTFCC_TX_ON_BIT];
    end
  end

  // full status FIFO holds sending unless overrun is allowed
  assign suspend_full = tsf_full && !status_overrun_allow;

  // permission to send; a pending stop still lets the running frame end
  always_comb begin
    next_tx_run = 1'b0;
    if (tx_on && !suspend_full) begin
      next_tx_run = !stop_req || tx_busy;
    end
  end

  // the full event goes on to the interrupt logic whatever the allow bit says
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_run       <= 1'b0;
      tsf_full_irq <= 1'b0;
    end else begin
      tx_run       <= next_tx_run;
      tsf_full_irq <= tsf_full;
    end
  end

  // padding counter; a receive flush also restarts its position
  rtfcc_pad u_pad (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .clear      (rx_ptr_clear),
    .align      (receive_align),
    .rd         (rx_rd),
    .last_data  (rx_last),
    .pad_active (pad_active),
    .pad_dword  (pad_dword)
  );

  // filler flag, one register late so it lines up with the next host read
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_pad <= 1'b0;
    end else begin
      rx_pad <= pad_dword && pad_active;
    end
  end

  // readback word; reserved and flush bits stay zero, the stop bit reads back its pending request
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (reg_addr)
      RTFCC_OFF_RX_CFG: begin
        next_rdata[RTFCC_RX_ALIGN_HI:RTFCC_RX_ALIGN_LO] = receive_align;
        next_rdata[RTFCC_RX_OFF_HI:RTFCC_RX_OFF_LO]     = receive_byte_offset;
      end
      RTFCC_OFF_TX_CFG: begin
        next_rdata[RTFCC_TX_SOA_BIT]  = status_overrun_allow;
        next_rdata[RTFCC_TX_ON_BIT]   = tx_on;
        next_rdata[RTFCC_TX_STOP_BIT] = stop_req;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read data register, held until the next read strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end
endmodule // rtfcc_top

/* File: rtfcc_monitor.sv */
/* rtfcc_monitor: port assertions for rtfcc_top.
   Assumes it is bound to rtfcc_top, one clock domain. */
`timescale 1ns/1ns
module rtfcc_monitor
  import rtfcc_pkg::*;
(
  input wire logic        clk_sys,       // clock
  input wire logic        rst_n,         // reset, low
  input wire logic [7:0]  reg_addr,      // address
  input wire logic        reg_wr,        // write
  input wire logic [31:0] reg_wdata,     // data
  input wire logic        tx_busy,       // frame on
  input wire logic        tsf_full,      // status full
  input wire logic        rx_rd,         // rx read
  input wire logic        rx_ptr_clear,  // rx flush
  input wire logic        txs_ptr_clear, // status flush
  input wire logic [4:0]  rx_offset_eff, // offset
  input wire logic        tx_run,        // may send
  input wire logic        tsf_full_irq   // irq event
);
  logic wt;
  logic soa;
  logic stp;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  assign wt = reg_wr && reg_addr == RTFCC_OFF_TX_CFG;
  // bus-side shadow of allow bit and pending stop
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      soa <= 1'b0;
      stp <= 1'b0;
    end else begin
      if (wt) soa <= reg_wdata[2];
      // a pending stop ignores writes and ends once no frame is out
      if (stp) begin
        if (!tx_busy) stp <= 1'b0;
      end else if (wt && reg_wdata[0]) stp <= 1'b1;
    end
  end
  AST_RX_FLUSH: assert property (reg_wr && reg_addr == RTFCC_OFF_RX_CFG && reg_wdata[15] |=> rx_ptr_clear)
    else $error("rx flush missing");
  AST_TXS_FLUSH: assert property (wt && reg_wdata[15] |=> txs_ptr_clear)
    else $error("status flush missing");
  AST_OFF_HOLD: assert property (!rx_rd |=> $stable(rx_offset_eff[4:2]))
    else $error("upper offset moved");
  AST_IRQ: assert property (tsf_full |=> tsf_full_irq)
    else $error("full event lost");
  AST_SUSPEND: assert property ((tsf_full && !soa)[*3] |-> !tx_run)
    else $error("sent while full");
  AST_RUN_ON: assert property (wt && reg_wdata[2:0] == 3'b110 && !stp |-> ##2 tx_run)
    else $error("enable ignored");
  AST_FINISH: assert property (stp && tx_busy && tx_run && soa |=> tx_run)
    else $error("frame cut");
  AST_HALT: assert property (stp && !tx_busy |-> ##2 !tx_run)
    else $error("no halt");
endmodule // rtfcc_monitor
bind rtfcc_top rtfcc_monitor u_mon (.*);

/* File: rtfcc_txeng.sv */
/* rtfcc_txeng: transmit engine model; sends frames while allowed and
   counts status words. Assumes the bench drives want. */
`timescale 1ns/1ns
module rtfcc_txeng #(parameter int FRAME = 12, parameter int DEPTH = 2) (
  input  wire logic clk_sys, // clock
  input  wire logic run,     // may send
  input  wire logic sclr,    // status clear
  input  wire logic want,    // frames queued
  output logic      busy,    // frame on
  output logic      full     // status full
);
  int cnt = 0;
  int gap = 0;
  int st = 0;
  initial busy = 1'b0;
  assign full = (st == DEPTH);
  // a started frame always runs out; gap keeps starts off a dying run
  always @(negedge clk_sys) begin
    if (sclr) st = 0;
    if (busy) begin
      cnt = cnt - 1;
      if (cnt == 0) begin
        busy = 1'b0;
        gap = 4;
        if (st < DEPTH) st = st + 1;
      end
    end else if (gap > 0) gap = gap - 1;
    else if (run && want) begin
      busy = 1'b1;
      cnt = FRAME;
    end
  end
endmodule // rtfcc_txeng

/* File: tb.sv */
/* tb: random and directed checks of rtfcc_top with an engine model.
   Assumes package, design, model and monitor compiled first. */
`timescale 1ns/1ns
`define check_eq(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
module tb;
  import rtfcc_pkg::*;
  logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rx_rd = 0, rx_last = 0, want = 0;
  logic rx_ptr_clear, txs_ptr_clear, txd_ptr_clear, rx_pad, tx_run, tsf_full_irq, tx_busy, tsf_full;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, d;
  logic [4:0] rx_offset_eff, off;
  logic [2:0] up;
  int bad_count = 0, num_checks = 0, seed = 32'h8e5a386d, n, k;
  always #10 clk_sys = ~clk_sys;
  rtfcc_top u_dut (.*);
  rtfcc_txeng u_eng (.clk_sys, .run(tx_run), .sclr(txs_ptr_clear), .want, .busy(tx_busy), .full(tsf_full));
  task automatic cyc(input int c);
    repeat (c) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    cyc(1);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr = a;
    reg_rd = 1;
    cyc(1);
    reg_rd = 0;
    `check_eq(reg_rdata, e)
  endtask
  // filler dwords after m data dwords at code a
  function automatic logic [31:0] pad_exp(input int a, input int m);
    int w;
    w = (a == 1) ? 4 : (a == 2) ? 8 : 1;
    return (w - m % w) % w;
  endfunction
  task automatic complete_run;
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles needed
  initial begin
    #100000;
    bad_count++;
    complete_run;
  end
  // main sequence: registers, offset, padding, transmitter
  initial begin
    cyc(5);
    rst_n = 1;
    rd(8'h6C, 32'h0);
    rd(8'h70, 32'h0);
    rd(8'h68, 32'h0);
    wr(8'h6C, 32'hFFFFFFFF);
    `check_eq(rx_ptr_clear, 1'b1)
    rd(8'h6C, 32'hC0001F00);
    wr(8'h70, 32'hFFFFC004);
    `check_eq({txs_ptr_clear, txd_ptr_clear}, 2'b11)
    rd(8'h70, 32'h4);
    up = 3'h0;
    for (k = 0; k < 6; k++) begin
      off = 5'($random(seed));
      wr(8'h6C, {2'(k), 14'h0, 1'b1, 2'h0, off, 8'h0});
      `check_eq(rx_ptr_clear, 1'b1)
      cyc(2);
      `check_eq(rx_offset_eff, {up, off[1:0]})
      rx_rd = 1;
      cyc(1);
      rx_rd = 0;
      cyc(2);
      up = off[4:2];
      `check_eq(rx_offset_eff, off)
      rd(8'h6C, {2'(k), 17'h0, off, 8'h0});
    end
    for (k = 0; k < 4; k++) begin
      n = 1 + {$random(seed)} % 9;
      wr(8'h6C, {2'(k), 14'h0, 1'b1, 15'h0});
      cyc(2);
      for (int i = 1; i <= n; i++) begin
        rx_last = (i == n);
        rx_rd = 1;
        cyc(1);
      end
      rx_rd = 0;
      rx_last = 0;
      cyc(1);
      d = 32'h0;
      while (rx_pad === 1'b1 && d < 9) begin
        rx_rd = 1;
        cyc(1);
        rx_rd = 0;
        cyc(1);
        d++;
      end
      `check_eq(d, pad_exp(k, n))
    end
    wr(8'h70, 32'h2);
    want = 1;
    cyc(2);
    `check_eq(tx_run, 1'b1)
    cyc(40);
    `check_eq({tsf_full_irq, tx_run}, 2'b10)
    wr(8'h70, 32'h6);
    cyc(2);
    `check_eq({tsf_full_irq, tx_run}, 2'b11)
    k = 0;
    while (tx_busy !== 1'b1 && k < 30) begin
      cyc(1);
      k++;
    end
    wr(8'h70, 32'h7);
    wr(8'h70, 32'h6);
    rd(8'h70, 32'h7);
    cyc(20);
    rd(8'h70, 32'h4);
    `check_eq({tx_run, tx_busy}, 2'b00)
    wr(8'h70, 32'h8000);
    cyc(2);
    `check_eq(tsf_full_irq, 1'b0)
    complete_run;
  end
endmodule // tb
